// file: design/lat_integration_select_timer.sv
`timescale 1ns/1ns
module lat_integration_select_timer #(
  parameter int unsigned INT0_CYC = lat_pkg::INT0_CYC,
  parameter int unsigned INT1_CYC = lat_pkg::INT1_CYC,
  parameter int unsigned INT2_CYC = lat_pkg::INT2_CYC
) (
  input wire logic core_clk_i,       // System clock
  input wire logic arst_n_i,         // Async reset, active low
  input wire logic [1:0] integration_select_sel_i, // Integration select field
  input wire logic manual_i,         // Manual start/stop bit
  output logic integrating_o,        // Integration running
  output logic done_o                // One-cycle end of integration
);
  import lat_pkg::*;

  logic [31:0] cnt_q;
  logic [1:0] sel_q;
  logic run_q;
  logic manual_mode;
  logic sel_chg;
  logic [31:0] last_cnt;

  function automatic logic [31:0] period_last(input logic [1:0] sel);
    case (sel)
      2'h0: period_last = INT0_CYC - 32'd1;
      2'h1: period_last = INT1_CYC - 32'd1;
      default: period_last = INT2_CYC - 32'd1;
    endcase
  endfunction : period_last

  assign manual_mode = (integration_select_sel_i == INTEGRATION_SELECT_MANUAL);
  assign sel_chg = (sel_q != integration_select_sel_i);
  assign last_cnt = period_last(integration_select_sel_i);
  assign done_o = manual_mode ? (run_q && !manual_i)
                              : (!sel_chg && cnt_q == last_cnt);
  assign integrating_o = run_q;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sel_q <= TIMING_RST[1:0];
      cnt_q <= 32'h0;
      run_q <= 1'b0;
    end else begin
      sel_q <= integration_select_sel_i;
      if (manual_mode) begin
        cnt_q <= 32'h0;
        if (manual_i && !run_q) begin
          run_q <= 1'b1;
        end else if (!manual_i && run_q) begin
          run_q <= 1'b0;
        end
      end else begin
        run_q <= 1'b1;
        if (sel_chg || cnt_q == last_cnt) begin
          cnt_q <= 32'h0;
        end else begin
          cnt_q <= cnt_q + 32'd1;
        end
      end
    end
  end

  property p_manual_start;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    manual_mode && manual_i && !run_q |=> integrating_o [*2];
  endproperty
  a_manual_start: assert property (p_manual_start) else $error("manual start missed");

  property p_manual_ignored;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    !manual_mode && !sel_chg && cnt_q != last_cnt |-> !done_o;
  endproperty
  a_manual_ignored: assert property (p_manual_ignored) else $error("stray end of cycle");

  c_manual_done: cover property (@(posedge core_clk_i) manual_mode && done_o);
endmodule : lat_integration_select_timer

// file: design/lat_light_adc_ctrl.sv
`timescale 1ns/1ns
module lat_light_adc_ctrl #(
  parameter logic [6:0] SLAVE_ADDR = 7'h2a,       // Bus address, arbitrary default
  parameter int unsigned INT0_CYC = lat_pkg::INT0_CYC,
  parameter int unsigned INT1_CYC = lat_pkg::INT1_CYC,
  parameter int unsigned INT2_CYC = lat_pkg::INT2_CYC
) (
  input wire logic core_clk_i,       // System clock, 10 MHz
  input wire logic arst_n_i,         // Async reset, active low
  input wire logic scl_i,            // Serial clock pin
  input wire logic sda_i,            // Serial data pin in
  output logic sda_o,                // Serial data pin out
  output logic sda_oe_o,             // Serial data drive enable
  input wire logic [15:0] ch0_data_i, // Channel 0 conversion result
  output logic gain_high_o,          // Both channels at 16x gain
  output logic integrating_o,        // Both channels integrating
  output logic int_n_o               // Interrupt, active low
);
  import lat_pkg::*;

  // ----------------------------------------
  // Pin synchronisers and bus events
  // ----------------------------------------
  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;
  logic scl_rise, scl_fall, start_det, stop_det;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else begin
      scl_s1_q <= scl_i;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_i;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  assign scl_rise = scl_s2_q && !scl_s3_q;
  assign scl_fall = !scl_s2_q && scl_s3_q;
  assign start_det = scl_s2_q && scl_s3_q && !sda_s2_q && sda_s3_q;
  assign stop_det = scl_s2_q && scl_s3_q && sda_s2_q && !sda_s3_q;

  // ----------------------------------------
  // Serial slave
  // ----------------------------------------
  lat_i2c_state_type st_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic first_q;
  logic idx_q;
  logic nack_q;
  logic ack_drv_q;
  logic tx_en_q;
  logic wr_stb;
  logic is_cmd;
  logic [3:0] ptr_q;
  logic word_q;
  logic [3:0] wr_addr;
  logic [3:0] rd_addr;
  logic [7:0] rd_data;

  assign wr_stb = (st_q == ST_WR_BYTE) && scl_fall && (bit_cnt_q == 4'h8);
  assign is_cmd = first_q && rx_q[CMD_POS];
  assign wr_addr = ptr_q + {3'h0, idx_q & word_q};
  assign rd_addr = ptr_q + {3'h0, idx_q & word_q};
  assign sda_o = 1'b0;
  assign sda_oe_o = ack_drv_q || (tx_en_q && !tx_q[7]);

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      first_q <= 1'b0;
      idx_q <= 1'b0;
      nack_q <= 1'b0;
      ack_drv_q <= 1'b0;
      tx_en_q <= 1'b0;
    end else if (start_det) begin
      st_q <= ST_ADDR;
      bit_cnt_q <= 4'h0;
      ack_drv_q <= 1'b0;
      tx_en_q <= 1'b0;
    end else if (stop_det) begin
      st_q <= ST_IDLE;
      ack_drv_q <= 1'b0;
      tx_en_q <= 1'b0;
    end else begin
      case (st_q)
        ST_ADDR, ST_WR_BYTE: begin
          if (scl_rise) begin
            rx_q <= {rx_q[6:0], sda_s2_q};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == 4'h8) begin
            bit_cnt_q <= 4'h0;
            if (st_q == ST_WR_BYTE) begin
              ack_drv_q <= 1'b1;
              st_q <= ST_WR_ACK;
              first_q <= 1'b0;
              if (!is_cmd) begin
                idx_q <= ~idx_q;
              end
            end else if (rx_q[7:1] == SLAVE_ADDR) begin
              ack_drv_q <= 1'b1;
              nack_q <= rx_q[0];
              st_q <= ST_ADDR_ACK;
            end else begin
              st_q <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            ack_drv_q <= 1'b0;
            idx_q <= 1'b0;
            if (nack_q) begin
              tx_q <= rd_data_at(ptr_q);
              tx_en_q <= 1'b1;
              bit_cnt_q <= 4'h1;
              st_q <= ST_RD_BYTE;
            end else begin
              first_q <= 1'b1;
              st_q <= ST_WR_BYTE;
            end
          end
        end
        ST_WR_ACK: begin
          if (scl_fall) begin
            ack_drv_q <= 1'b0;
            st_q <= ST_WR_BYTE;
          end
        end
        ST_RD_BYTE: begin
          if (scl_fall) begin
            if (bit_cnt_q == 4'h8) begin
              tx_en_q <= 1'b0;
              st_q <= ST_RD_ACK;
            end else begin
              tx_q <= {tx_q[6:0], 1'b0};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            nack_q <= sda_s2_q;
            idx_q <= ~idx_q;
          end else if (scl_fall) begin
            if (nack_q) begin
              st_q <= ST_IDLE;
            end else begin
              tx_q <= rd_data;
              tx_en_q <= 1'b1;
              bit_cnt_q <= 4'h1;
              st_q <= ST_RD_BYTE;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0] timing_q;
  logic [7:0] tlo_lsb_q, tlo_msb_q, thi_lsb_q, thi_msb_q;
  logic [5:0] irq_cfg_q;
  logic clr_stb;

  function automatic logic [7:0] rd_data_at(input logic [3:0] a);
    case (a)
      ADDR_TIMING: rd_data_at = {3'h0, timing_q[4:3], 1'b0, timing_q[1:0]};
      ADDR_TLO_LSB: rd_data_at = tlo_lsb_q;
      ADDR_TLO_MSB: rd_data_at = tlo_msb_q;
      ADDR_THI_LSB: rd_data_at = thi_lsb_q;
      ADDR_THI_MSB: rd_data_at = thi_msb_q;
      ADDR_IRQ_CFG: rd_data_at = {2'h0, irq_cfg_q};
      default: rd_data_at = 8'h00;
    endcase
  endfunction : rd_data_at

  assign rd_data = rd_data_at(rd_addr);
  assign clr_stb = wr_stb && is_cmd && rx_q[CLEAR_POS];

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ptr_q <= CMD_RST[3:0];
      word_q <= CMD_RST[WORD_POS];
    end else if (wr_stb && is_cmd) begin
      ptr_q <= rx_q[3:0];
      word_q <= rx_q[WORD_POS];
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      timing_q <= TIMING_RST;
      tlo_lsb_q <= THR_RST;
      tlo_msb_q <= THR_RST;
      thi_lsb_q <= THR_RST;
      thi_msb_q <= THR_RST;
      irq_cfg_q <= IRQ_CFG_RST[5:0];
    end else if (wr_stb && !is_cmd) begin
      case (wr_addr)
        ADDR_TIMING: timing_q <= {3'h0, rx_q[4:3], 1'b0, rx_q[1:0]};
        ADDR_TLO_LSB: tlo_lsb_q <= rx_q;
        ADDR_TLO_MSB: tlo_msb_q <= rx_q;
        ADDR_THI_LSB: thi_lsb_q <= rx_q;
        ADDR_THI_MSB: thi_msb_q <= rx_q;
        ADDR_IRQ_CFG: irq_cfg_q <= rx_q[5:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Integration control, shared by both channels
  // ----------------------------------------
  logic integration_select_done;

  assign gain_high_o = timing_q[GAIN_POS];

  lat_integration_select_timer #(
    .INT0_CYC(INT0_CYC),
    .INT1_CYC(INT1_CYC),
    .INT2_CYC(INT2_CYC)
  ) u_timer (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .integration_select_sel_i(timing_q[1:0]),
    .manual_i(timing_q[MANUAL_POS]),
    .integrating_o(integrating_o),
    .done_o(integration_select_done)
  );

  // ----------------------------------------
  // Threshold window and persistence
  // ----------------------------------------
  logic [15:0] thr_low, thr_high;
  logic out_win;
  logic [3:0] persist;
  logic level_mode;
  logic [3:0] pcnt_q;
  logic [3:0] pcnt_inc;
  logic irq_set;
  logic pend_q;

  assign thr_low = {tlo_msb_q, tlo_lsb_q};
  assign thr_high = {thi_msb_q, thi_lsb_q};
  assign out_win = (ch0_data_i <= thr_low) || (ch0_data_i > thr_high);
  assign persist = irq_cfg_q[3:0];
  assign level_mode = (irq_cfg_q[5:4] == INTR_LEVEL);
  assign pcnt_inc = (pcnt_q == 4'hf) ? 4'hf : pcnt_q + 4'h1;
  assign irq_set = integration_select_done && level_mode &&
                   ((persist == 4'h0) ||
                    (out_win && pcnt_inc >= persist));

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pcnt_q <= 4'h0;
    end else if (integration_select_done) begin
      pcnt_q <= out_win ? pcnt_inc : 4'h0;
    end else if (clr_stb) begin
      pcnt_q <= 4'h0;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pend_q <= 1'b0;
    end else if (irq_set) begin
      pend_q <= 1'b1;
    end else if (clr_stb) begin
      pend_q <= 1'b0;
    end
  end

  assign int_n_o = !(pend_q && level_mode);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_gain_write;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    wr_stb && !is_cmd && wr_addr == ADDR_TIMING |=> gain_high_o == $past(rx_q[GAIN_POS]);
  endproperty
  a_gain_write: assert property (p_gain_write) else $error("gain not updated");

  property p_hold;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    !int_n_o && !clr_stb && !(wr_stb && !is_cmd && wr_addr == ADDR_IRQ_CFG) |=> !int_n_o;
  endproperty
  a_hold: assert property (p_hold) else $error("interrupt dropped without clear");

  property p_clear;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    clr_stb && !integration_select_done |=> int_n_o && pcnt_q == 4'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not release");

  property p_disabled;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    irq_cfg_q[5:4] == INTR_OFF |-> int_n_o;
  endproperty
  a_disabled: assert property (p_disabled) else $error("interrupt while disabled");

  property p_every;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    integration_select_done && level_mode && persist == 4'h0 |=> !int_n_o;
  endproperty
  a_every: assert property (p_every) else $error("no per-cycle interrupt");

  property p_single;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    integration_select_done && level_mode && persist == 4'h1 && out_win |=> !int_n_o;
  endproperty
  a_single: assert property (p_single) else $error("out-of-window missed");

  property p_early;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    integration_select_done && persist > 4'h1 && pcnt_inc < persist && !pend_q |=> int_n_o;
  endproperty
  a_early: assert property (p_early) else $error("interrupt before count");

  property p_inwin;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    integration_select_done && !out_win |=> pcnt_q == 4'h0;
  endproperty
  a_inwin: assert property (p_inwin) else $error("count not reset");

  property p_cmd_ptr;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    wr_stb && is_cmd |=> ptr_q == $past(rx_q[3:0]) && $stable(thr_low) && $stable(thr_high);
  endproperty
  a_cmd_ptr: assert property (p_cmd_ptr) else $error("command byte mishandled");

  c_irq: cover property (@(posedge core_clk_i) $fell(int_n_o));
  c_clear: cover property (@(posedge core_clk_i) clr_stb && !int_n_o);
  c_persist: cover property (@(posedge core_clk_i) irq_set && persist > 4'h1);
endmodule : lat_light_adc_ctrl

// file: design/lat_pkg.sv
package lat_pkg;
  // Register pointer values
  localparam logic [3:0] ADDR_TIMING = 4'h1;
  localparam logic [3:0] ADDR_TLO_LSB = 4'h2;
  localparam logic [3:0] ADDR_TLO_MSB = 4'h3;
  localparam logic [3:0] ADDR_THI_LSB = 4'h4;
  localparam logic [3:0] ADDR_THI_MSB = 4'h5;
  localparam logic [3:0] ADDR_IRQ_CFG = 4'h6;
  // Reset values
  localparam logic [7:0] TIMING_RST = 8'h02;
  localparam logic [7:0] THR_RST = 8'h00;
  localparam logic [7:0] IRQ_CFG_RST = 8'h00;
  localparam logic [7:0] CMD_RST = 8'h00;
  // Field positions
  localparam int GAIN_POS = 4;
  localparam int MANUAL_POS = 3;
  localparam int CMD_POS = 7;
  localparam int CLEAR_POS = 6;
  localparam int WORD_POS = 5;
  // Field codes
  localparam logic [1:0] INTEGRATION_SELECT_MANUAL = 2'h3;
  localparam logic [1:0] INTR_OFF = 2'h0;
  localparam logic [1:0] INTR_LEVEL = 2'h1;
  // Integration timing
  localparam int CLK_KHZ = 10000;
  localparam int T_INT0_US = 13700;
  localparam int T_INT1_US = 101000;
  localparam int T_INT2_US = 402000;
  localparam int INT0_CYC = T_INT0_US * (CLK_KHZ / 1000);
  localparam int INT1_CYC = T_INT1_US * (CLK_KHZ / 1000);
  localparam int INT2_CYC = T_INT2_US * (CLK_KHZ / 1000);
  // Serial slave states
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_BYTE, ST_WR_ACK, ST_RD_BYTE, ST_RD_ACK
  } lat_i2c_state_type;
endpackage : lat_pkg

// file: verif/lat_host_model.sv
`timescale 1ns/1ns
module lat_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2a // Arbitrary, matches design default
) (
  input wire logic core_clk_i, // System clock
  input wire logic sda_i, // Resolved data line
  output logic scl_o, // Serial clock, idle high
  output logic sda_low_o, // Pulls data line low
  output logic rd_stb_o, // One cycle per byte read
  output logic [7:0] rd_data_o // Last byte read
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    rd_stb_o = 1'b0;
    rd_data_o = 8'h00;
  end
  // ----------------------------------------
  // Line phases, 400 ns each
  // ----------------------------------------
  task automatic half();
    repeat (4) @(negedge core_clk_i);
  endtask : half
  task automatic start();
    @(negedge core_clk_i);
    sda_low_o = 1'b0;
    half();
    scl_o = 1'b1;
    half();
    sda_low_o = 1'b1;
    half();
    scl_o = 1'b0;
  endtask : start
  task automatic stop();
    @(negedge core_clk_i);
    sda_low_o = 1'b1;
    half();
    scl_o = 1'b1;
    half();
    sda_low_o = 1'b0;
    half();
  endtask : stop
  // Data moves one clock after the fall so it never races the clock edge
  task automatic xfer(input logic b, output logic v);
    @(negedge core_clk_i);
    sda_low_o = ~b;
    repeat (3) @(negedge core_clk_i);
    scl_o = 1'b1;
    half();
    v = sda_i;
    scl_o = 1'b0;
  endtask : xfer
  task automatic wr_byte(input logic [7:0] b);
    logic v;
    for (int i = 7; i >= 0; i--) xfer(b[i], v);
    xfer(1'b1, v);
  endtask : wr_byte
  task automatic rd_byte(input logic last);
    logic [7:0] d;
    logic v;
    for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
    xfer(last, v);
    rd_data_o = d;
    rd_stb_o = 1'b1;
    @(negedge core_clk_i);
    rd_stb_o = 1'b0;
  endtask : rd_byte
  // ----------------------------------------
  // Transactions
  // ----------------------------------------
  task automatic write(input logic [7:0] cmd, input int n, input logic [15:0] dat);
    start();
    wr_byte({DEV_ADDR, 1'b0});
    wr_byte(cmd);
    for (int i = 0; i < n; i++) wr_byte(dat[8*i +: 8]);
    stop();
  endtask : write
  task automatic read(input logic use_cmd, input logic [7:0] cmd, input int n);
    if (use_cmd) begin
      start();
      wr_byte({DEV_ADDR, 1'b0});
      wr_byte(cmd);
    end
    start();
    wr_byte({DEV_ADDR, 1'b1});
    for (int i = 0; i < n; i++) rd_byte(i == n - 1);
    stop();
  endtask : read
endmodule : lat_host_model

// file: verif/tb.sv
`timescale 1ns/1ns
module tb;
  import lat_pkg::*;
  localparam int P0 = 400;
  localparam int P1 = 500;
  localparam int P2 = 600;
  logic core_clk_i, arst_n_i, scl, sda_low, sda, sda_oe, gain_high, integrating, int_n, rd_stb;
  logic sda_out;
  logic [7:0] rd_data;
  logic [15:0] ch0_data;
  logic [31:0] lfsr_q;
  logic [7:0] exp_q[$];
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int per[3] = '{P0, P1, P2};
  assign sda = ~((sda_oe & ~sda_out) | sda_low);
  lat_light_adc_ctrl #(.INT0_CYC(P0), .INT1_CYC(P1), .INT2_CYC(P2)) i_lat_light_adc_ctrl (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_out),
    .sda_oe_o(sda_oe), .ch0_data_i(ch0_data), .gain_high_o(gain_high),
    .integrating_o(integrating), .int_n_o(int_n));
  lat_host_model i_lat_host_model (.core_clk_i(core_clk_i), .sda_i(sda), .scl_o(scl),
    .sda_low_o(sda_low), .rd_stb_o(rd_stb), .rd_data_o(rd_data));
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("Counts: %0d compares, %0d mismatches", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      complete_run();
    end
  end
  always @(posedge core_clk_i) begin
    if (rd_stb === 1'b1) begin
      if (exp_q.size() == 0) check({8'h00, rd_data}, 16'hxxxx);
      else check({8'h00, rd_data}, {8'h00, exp_q.pop_front()});
    end
  end
  // ----------------------------------------
  // Stimulus helpers
  // ----------------------------------------
  task automatic rd_expect(input logic [3:0] p, input int n, input logic [15:0] e);
    exp_q.push_back(e[7:0]);
    if (n == 2) exp_q.push_back(e[15:8]);
    i_lat_host_model.read(1'b1, {2'b10, n == 2, 1'b0, p}, n);
  endtask : rd_expect
  task automatic wr_timing(input logic [7:0] v);
    i_lat_host_model.write(8'h81, 1, {8'h00, v});
  endtask : wr_timing
  task automatic cfg(input logic [7:0] v);
    i_lat_host_model.write(8'hc6, 1, {8'h00, v});
  endtask : cfg
  // One manual integration: start then stop in one transaction
  task automatic integration_select(input logic [15:0] v, input logic e);
    ch0_data = v;
    i_lat_host_model.write(8'h81, 2, 16'h030b);
    check(int_n, e);
  endtask : integration_select
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [15:0] lo, md, hi;
    logic [15:0] sv[7];
    logic se[7];
    logic [7:0] tv[5];
    logic ti[5];
    int w;
    arst_n_i = 1'b0;
    ch0_data = 16'h0000;
    lfsr_q = 32'h9a9e;
    repeat (12) @(negedge core_clk_i);
    arst_n_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    check(gain_high, 1'b0);
    check(int_n, 1'b1);
    for (int p = 1; p < 8; p++) rd_expect(4'(p), 1, (p == 1) ? 16'h0002 : 16'h0000);
    $display("reset values done");
    lfsr_q = lfsr_next(lfsr_q);
    lo = {4'h1, lfsr_q[11:0]};
    md = {4'h4, lfsr_q[11:0]};
    lfsr_q = lfsr_next(lfsr_q);
    hi = {4'h8, lfsr_q[23:12]};
    i_lat_host_model.write(8'ha2, 2, lo);
    i_lat_host_model.write(8'ha4, 2, hi);
    rd_expect(4'h2, 2, lo);
    rd_expect(4'h4, 2, hi);
    i_lat_host_model.write(8'h82, 0, 16'h0000);
    exp_q.push_back(lo[7:0]);
    i_lat_host_model.read(1'b0, 8'h00, 1);
    $display("thresholds done");
    wr_timing(8'h12);
    check(gain_high, 1'b1);
    rd_expect(4'h1, 1, 16'h0012);
    wr_timing(8'h03);
    check(gain_high, 1'b0);
    check(integrating, 1'b0);
    $display("gain done");
    cfg(8'h10);
    for (int k = 0; k < 3; k++) begin
      // Clear after the new setting so a done of the old period cannot linger
      wr_timing(8'(k));
      i_lat_host_model.write(8'hc0, 0, 16'h0000);
      check(int_n, 1'b1);
      for (w = 0; w < 1000 && int_n !== 1'b0; w++) @(negedge core_clk_i);
      w = cycles;
      i_lat_host_model.write(8'hc0, 0, 16'h0000);
      for (int j = 0; j < 1000 && int_n !== 1'b0; j++) @(negedge core_clk_i);
      check(16'(cycles - w), 16'(per[k]));
    end
    i_lat_host_model.write(8'hc1, 1, 16'h0003);
    $display("integration periods done");
    cfg(8'h00);
    tv = '{8'h0b, 8'h03, 8'h08, 8'h00, 8'h03};
    ti = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 5; i++) begin
      wr_timing(tv[i]);
      check(integrating, ti[i]);
    end
    check(int_n, 1'b1);
    $display("manual control done");
    cfg(8'h13);
    sv = '{hi + 16'h0001, lo, md, hi, lo, hi + 16'h0001, 16'h0000};
    se = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 7; i++) integration_select(sv[i], se[i]);
    integration_select(md, 1'b0);
    i_lat_host_model.write(8'hc0, 0, 16'h0000);
    check(int_n, 1'b1);
    integration_select(lo, 1'b1);
    integration_select(lo, 1'b1);
    cfg(8'h1f);
    for (int i = 0; i < 15; i++) integration_select(lo, i < 14);
    cfg(8'h11);
    integration_select(md, 1'b1);
    integration_select(lo, 1'b0);
    for (int m = 0; m < 4; m++) begin
      cfg({2'b00, 2'(m), 4'h0});
      integration_select(md, m != 1);
    end
    $display("interrupt persistence done");
    complete_run();
  end
endmodule : tb
